// ===== shared/standby_pkg.sv
package standby_pkg;

    // Interrupt sources watched by the standby logic
    localparam int N_IRQ = 4;

    // Register map (byte addresses)
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;

    // Control register field positions
    localparam int CTRL_OSC_STABILIZATION_TIME_SELECT_LSB = 0;
    localparam int CTRL_OSC_STABILIZATION_TIME_SELECT_W = 3;
    localparam int CTRL_SEL_A_BIT = 3;
    localparam int CTRL_SEL_B_BIT = 4;
    localparam int CTRL_H0_BIT = 5;
    localparam int CTRL_WATCH_BIT = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // Status register field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_VEC_BIT = 3;
    localparam int STAT_PEND_LSB = 8;

    // CPU clock source codes
    localparam logic [1:0] SRC_HIGH_SPEED = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_SUBSYSTEM = 2'h2;

    // Wake wait counts in CPU clocks
    localparam logic [15:0] WAIT_VECTOR = 16'h0008;
    localparam logic [15:0] WAIT_RESUME = 16'h0002;

    // Largest oscillation stabilization select code
    localparam logic [2:0] OSC_STABILIZATION_TIME_SELECT_MAX = 3'h4;

    // Standby states, Gray steps along run-halt-wake and run-stop-osc
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_HALT = 3'h1,
        ST_WAKE = 3'h3,
        ST_STOP = 3'h2,
        ST_OSC = 3'h6
    } state_e;

endpackage : standby_pkg

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] pin_i, // Raw pin levels
    output logic [WIDTH-1:0] sync_o // Synchronised levels
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_s;

    sync_s cur;
    sync_s next_cur;

    // Per-bit two-stage chain
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_bit
        always_comb begin
            next_cur.meta[g] = pin_i[g];
            next_cur.sync[g] = cur.meta[g];
        end
    end

    // Chain registers
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cur <= {INIT, INIT};
        end else begin
            cur <= next_cur;
        end
    end

    assign sync_o = cur.sync;

endmodule : pin_sync

// ===== rtl/wait_counter.sv
// Down counter for wake and stabilization waits
module wait_counter (
    input wire logic clock_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic load_i, // Start a new wait
    input wire logic [15:0] value_i, // Wait length in cycles
    output logic done_o // High in last cycle of the wait
);

    typedef struct packed {
        logic [15:0] cnt;
    } cnt_s;

    cnt_s cur;
    cnt_s next_cur;

    // Load or count down to zero
    always_comb begin
        next_cur = cur;
        if (load_i) begin
            next_cur.cnt = value_i;
        end else if (cur.cnt != 16'h0000) begin
            next_cur.cnt = cur.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done_o = (cur.cnt == 16'h0001) && !load_i;

endmodule : wait_counter

// ===== rtl/standby_ctrl.sv
// Behaviour
// - In halt, any pending request with its mask flag clear wakes the device.
// - A halt wake takes the vector when acknowledge is allowed, else resumes inline.
// - A halt wake into vectored servicing waits eight clocks before the vector.
// - A halt wake that resumes inline waits two clocks before resuming.
// - The reset pin ends halt regardless of flags and starts from the reset vector.
// - Service needs high priority with enable set, or low priority with enable and in-service set.
// - The stop instruction enters stop only from the high-speed or internal clock.
// - A halt instruction with an unmasked request already pending releases at once.
// - Stop with a pending request skips stop and returns after the stabilization wait.
// - In stop each 8-bit counter runs only when its external count pin is selected.
// - In stop timer H0 runs only when clocked from a running first 8-bit counter.
// - In stop the watch timer runs only when the subsystem clock is its source.
module standby_ctrl #(
    parameter logic [15:0] OSC_BASE_CYCLES = 16'h0100
) (
    input wire logic clock_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic reset_pin_n_i, // External reset pin, active low
    input wire logic halt_instr_i, // Halt instruction executed
    input wire logic stop_instr_i, // Stop instruction executed
    input wire logic [1:0] cpu_clk_src_i, // CPU clock source code
    input wire logic [standby_pkg::N_IRQ-1:0] int_req_i, // Interrupt request flags
    input wire logic [standby_pkg::N_IRQ-1:0] interrupt_mask_flag_i, // Mask flags
    input wire logic [standby_pkg::N_IRQ-1:0] interrupt_priority_flag_i, // 1 is low priority
    input wire logic global_interrupt_enable_flag_i, // Acknowledge enable
    input wire logic in_service_priority_flag_i, // In-service priority flag
    input wire logic [7:0] addr_i, // Register address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    output logic cpu_clk_en_o, // CPU clock gate enable
    output logic hs_osc_en_o, // High-speed oscillator enable
    output logic port_hold_o, // Port output latches held
    output logic tmr8a_run_o, // First 8-bit counter may run
    output logic tmr8b_run_o, // Second 8-bit counter may run
    output logic tmrh0_run_o, // Timer H0 may run
    output logic watch_run_o, // Watch timer may run
    output logic tmr16_run_o, // 16-bit counters may run
    output logic vector_o, // Take vectored interrupt, pulse
    output logic resume_o, // Resume at next instruction, pulse
    output logic reset_vector_o, // Branch to reset vector, pulse
    output logic [2:0] state_o // Standby state
);

    typedef struct packed {
        standby_pkg::state_e st;
        logic take_vec;
        logic [2:0] osc_stabilization_time_select;
        logic sel_a;
        logic sel_b;
        logic h0_sel;
        logic watch_sub;
        logic cpu_clk_en;
        logic hs_osc_en;
        logic port_hold;
        logic t8a;
        logic t8b;
        logic th0;
        logic tw;
        logic t16;
        logic vector;
        logic resume;
        logic rst_vec;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s cur;
    ctrl_s next_cur;
    logic pin_ok;
    logic cnt_load;
    logic [15:0] cnt_value;
    logic cnt_done;
    logic [standby_pkg::N_IRQ-1:0] pend;
    logic any_pend;
    logic svc;
    logic clk_ok;

    // Reset pin comes from outside the clock domain
    pin_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) u_pin_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .pin_i(reset_pin_n_i),
        .sync_o(pin_ok)
    );

    // Shared wait counter for wake and stabilization
    wait_counter u_wait (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .load_i(cnt_load),
        .value_i(cnt_value),
        .done_o(cnt_done)
    );

    // Unmasked pending requests
    assign pend = int_req_i & ~interrupt_mask_flag_i;
    assign any_pend = |pend;
    assign clk_ok = (cpu_clk_src_i == standby_pkg::SRC_HIGH_SPEED) ||
                    (cpu_clk_src_i == standby_pkg::SRC_INTERNAL);

    always_comb begin
        if (|(pend & ~interrupt_priority_flag_i)) begin
            svc = global_interrupt_enable_flag_i;
        end else begin
            svc = global_interrupt_enable_flag_i && in_service_priority_flag_i;
        end
    end

    // Next state, registers and outputs
    always_comb begin
        next_cur = cur;
        cnt_load = 1'b0;
        cnt_value = standby_pkg::WAIT_RESUME;
        next_cur.vector = 1'b0;
        next_cur.resume = 1'b0;
        next_cur.rst_vec = 1'b0;
        next_cur.rdata = 32'h0000_0000;
        // Control register write
        if (wr_i && addr_i == standby_pkg::CTRL_ADDR) begin
            if (wdata_i[standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_LSB +: standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_W] >
                    standby_pkg::OSC_STABILIZATION_TIME_SELECT_MAX) begin
                next_cur.osc_stabilization_time_select = standby_pkg::OSC_STABILIZATION_TIME_SELECT_MAX;
            end else begin
                next_cur.osc_stabilization_time_select = wdata_i[standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_LSB +: standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_W];
            end
            next_cur.sel_a = wdata_i[standby_pkg::CTRL_SEL_A_BIT];
            next_cur.sel_b = wdata_i[standby_pkg::CTRL_SEL_B_BIT];
            next_cur.h0_sel = wdata_i[standby_pkg::CTRL_H0_BIT];
            next_cur.watch_sub = wdata_i[standby_pkg::CTRL_WATCH_BIT];
        end
        // Register read, data valid next cycle
        if (rd_i) begin
            unique case (addr_i)
                standby_pkg::CTRL_ADDR: begin
                    next_cur.rdata[standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_LSB +: standby_pkg::CTRL_OSC_STABILIZATION_TIME_SELECT_W] =
                        cur.osc_stabilization_time_select;
                    next_cur.rdata[standby_pkg::CTRL_SEL_A_BIT] = cur.sel_a;
                    next_cur.rdata[standby_pkg::CTRL_SEL_B_BIT] = cur.sel_b;
                    next_cur.rdata[standby_pkg::CTRL_H0_BIT] = cur.h0_sel;
                    next_cur.rdata[standby_pkg::CTRL_WATCH_BIT] = cur.watch_sub;
                end
                standby_pkg::STATUS_ADDR: begin
                    next_cur.rdata[standby_pkg::STAT_STATE_LSB +: 3] = cur.st;
                    next_cur.rdata[standby_pkg::STAT_VEC_BIT] = cur.take_vec;
                    next_cur.rdata[standby_pkg::STAT_PEND_LSB +: standby_pkg::N_IRQ] = pend;
                end
                default: begin
                    next_cur.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Standby sequencing
        unique case (cur.st)
            standby_pkg::ST_RUN: begin
                if (halt_instr_i) begin
                    // Pending at halt wakes at once
                    if (any_pend) begin
                        next_cur.st = standby_pkg::ST_WAKE;
                        next_cur.take_vec = svc;
                        cnt_load = 1'b1;
                        cnt_value = svc ? standby_pkg::WAIT_VECTOR : standby_pkg::WAIT_RESUME;
                    end else begin
                        next_cur.st = standby_pkg::ST_HALT;
                    end
                end else if (stop_instr_i) begin
                    if (!clk_ok) begin
                        next_cur.resume = 1'b1;
                    // Pending stop drops to stabilization wait
                    end else if (any_pend) begin
                        next_cur.st = standby_pkg::ST_OSC;
                        next_cur.take_vec = svc;
                        cnt_load = 1'b1;
                        cnt_value = 16'(OSC_BASE_CYCLES << cur.osc_stabilization_time_select);
                    end else begin
                        next_cur.st = standby_pkg::ST_STOP;
                    end
                end
            end
            standby_pkg::ST_HALT: begin
                if (any_pend) begin
                    next_cur.st = standby_pkg::ST_WAKE;
                    next_cur.take_vec = svc;
                    cnt_load = 1'b1;
                    cnt_value = svc ? standby_pkg::WAIT_VECTOR : standby_pkg::WAIT_RESUME;
                end
            end
            standby_pkg::ST_STOP: begin
                // Unmasked request restarts oscillator
                if (any_pend) begin
                    next_cur.st = standby_pkg::ST_OSC;
                    next_cur.take_vec = svc;
                    cnt_load = 1'b1;
                    cnt_value = 16'(OSC_BASE_CYCLES << cur.osc_stabilization_time_select);
                end
            end
            standby_pkg::ST_WAKE, standby_pkg::ST_OSC: begin
                if (cnt_done) begin
                    next_cur.st = standby_pkg::ST_RUN;
                    next_cur.vector = cur.take_vec;
                    next_cur.resume = !cur.take_vec;
                end
            end
            default: begin
                next_cur.st = standby_pkg::ST_RUN;
            end
        endcase
        if (!pin_ok) begin
            next_cur.st = standby_pkg::ST_RUN;
            next_cur.take_vec = 1'b0;
            next_cur.vector = 1'b0;
            next_cur.resume = 1'b0;
            next_cur.rst_vec = 1'b1;
        end
        next_cur.cpu_clk_en = (next_cur.st == standby_pkg::ST_RUN);
        next_cur.hs_osc_en = (next_cur.st != standby_pkg::ST_STOP);
        next_cur.port_hold = (next_cur.st == standby_pkg::ST_STOP);
        next_cur.t16 = (next_cur.st != standby_pkg::ST_STOP);
        next_cur.t8a = (next_cur.st != standby_pkg::ST_STOP) || next_cur.sel_a;
        next_cur.t8b = (next_cur.st != standby_pkg::ST_STOP) || next_cur.sel_b;
        next_cur.th0 = (next_cur.st != standby_pkg::ST_STOP) ||
                       (next_cur.h0_sel && next_cur.sel_a);
        next_cur.tw = (next_cur.st != standby_pkg::ST_STOP) || next_cur.watch_sub;
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cur <= '0;
            cur.st <= standby_pkg::ST_RUN;
            cur.cpu_clk_en <= 1'b1;
            cur.hs_osc_en <= 1'b1;
            cur.t8a <= 1'b1;
            cur.t8b <= 1'b1;
            cur.th0 <= 1'b1;
            cur.tw <= 1'b1;
            cur.t16 <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from flops
    assign rdata_o = cur.rdata;
    assign cpu_clk_en_o = cur.cpu_clk_en;
    assign hs_osc_en_o = cur.hs_osc_en;
    assign port_hold_o = cur.port_hold;
    assign tmr8a_run_o = cur.t8a;
    assign tmr8b_run_o = cur.t8b;
    assign tmrh0_run_o = cur.th0;
    assign watch_run_o = cur.tw;
    assign tmr16_run_o = cur.t16;
    assign vector_o = cur.vector;
    assign resume_o = cur.resume;
    assign reset_vector_o = cur.rst_vec;
    assign state_o = cur.st;

    // Checks
    property p_halt_wake;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_HALT && any_pend && pin_ok) |=>
            (cur.st == standby_pkg::ST_WAKE);
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not left");

    property p_masked_hold;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_HALT && !any_pend && pin_ok) |=>
            (cur.st == standby_pkg::ST_HALT);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("halt left");

    property p_vec_wait;
        @(posedge clock_i) disable iff (!resetn_i || !pin_ok || !reset_pin_n_i)
        (cur.st == standby_pkg::ST_HALT && any_pend && svc) |->
            ##1 (!vector_o && !resume_o) [*8] ##1 vector_o;
    endproperty
    a_vec_wait: assert property (p_vec_wait) else $error("vector wait");

    property p_res_wait;
        @(posedge clock_i) disable iff (!resetn_i || !pin_ok || !reset_pin_n_i)
        (cur.st == standby_pkg::ST_HALT && any_pend && !svc) |->
            ##3 (resume_o && !vector_o);
    endproperty
    a_res_wait: assert property (p_res_wait) else $error("resume wait");

    property p_one_exit;
        @(posedge clock_i) disable iff (!resetn_i)
        !(vector_o && resume_o);
    endproperty
    a_one_exit: assert property (p_one_exit) else $error("double exit");

    property p_pin_reset;
        @(posedge clock_i) disable iff (!resetn_i)
        !pin_ok |=> (reset_vector_o && cur.st == standby_pkg::ST_RUN && cpu_clk_en_o);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset");

    property p_stop_src;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_RUN && stop_instr_i && !halt_instr_i && !clk_ok) |=>
            (cur.st != standby_pkg::ST_STOP);
    endproperty
    a_stop_src: assert property (p_stop_src) else $error("stop from slow clock");

    property p_stop_pend;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_RUN && stop_instr_i && !halt_instr_i && clk_ok &&
         any_pend && pin_ok) |=> (cur.st == standby_pkg::ST_OSC && hs_osc_en_o);
    endproperty
    a_stop_pend: assert property (p_stop_pend) else $error("pending stop");

    property p_stop_pins;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_STOP) |->
            (tmr8a_run_o == cur.sel_a && tmr8b_run_o == cur.sel_b &&
             tmrh0_run_o == (cur.h0_sel && cur.sel_a) && watch_run_o == cur.watch_sub);
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("stop timers");

    property p_stop_core;
        @(posedge clock_i) disable iff (!resetn_i)
        (cur.st == standby_pkg::ST_STOP) |->
            (!hs_osc_en_o && !cpu_clk_en_o && port_hold_o && !tmr16_run_o);
    endproperty
    a_stop_core: assert property (p_stop_core) else $error("stop clocks");

    c_vec: cover property (@(posedge clock_i) disable iff (!resetn_i) vector_o);
    c_res: cover property (@(posedge clock_i) disable iff (!resetn_i)
        cur.st == standby_pkg::ST_WAKE ##1 resume_o);
    c_stop: cover property (@(posedge clock_i) disable iff (!resetn_i)
        cur.st == standby_pkg::ST_STOP ##1 cur.st == standby_pkg::ST_OSC);
    c_rst: cover property (@(posedge clock_i) disable iff (!resetn_i) reset_vector_o);

endmodule : standby_ctrl

// ===== test/cpu_seq_model.sv
// CPU sequencer and interrupt controller seen from the standby block
module cpu_seq_model (
    input wire logic clock_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic do_halt_i, // Bench asks for a halt instruction
    input wire logic do_stop_i, // Bench asks for a stop instruction
    input wire logic [standby_pkg::N_IRQ-1:0] raise_i, // Request flags to set
    input wire logic drop_i, // Software clears all request flags
    input wire logic vector_i, // Device takes the vector
    input wire logic cpu_clk_en_i, // CPU clock running
    output logic halt_instr_o, // Halt instruction pulse
    output logic stop_instr_o, // Stop instruction pulse
    output logic [standby_pkg::N_IRQ-1:0] int_req_o // Request flags
);
    timeunit 1ns;
    timeprecision 100ps;

    // Instructions execute only while the CPU is clocked
    always_ff @(posedge clock_i) begin
        halt_instr_o <= do_halt_i & cpu_clk_en_i & resetn_i;
        stop_instr_o <= do_stop_i & cpu_clk_en_i & resetn_i;
    end

    // Flags stay set until acknowledged by the vector or cleared
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            int_req_o <= '0;
        end else begin
            int_req_o <= (int_req_o | raise_i) & ~{standby_pkg::N_IRQ{vector_i | drop_i}};
        end
    end
endmodule : cpu_seq_model

// ===== test/standby_halt_stop_control_tb.sv
// Self-checking bench for the standby controller
module standby_halt_stop_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic stp;
        logic pr;
        logic ie;
        logic in_service_priority_flag;
        logic [6:0] ctrl;
        logic vec;
    } row_s;

    logic clock_i = 0, resetn_i = 0, pin_n = 1, do_halt = 0, do_stop = 0, drop = 0, ie = 0, in_service_priority_flag = 0;
    logic [3:0] raise = 0, mask = 4'hf, pri = 0;
    logic [1:0] src = 2'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic wr = 0, rd = 0, halt_i, stop_i, clk_en, osc_en, hold, ra, rb, rh0, rw, r16, vec, res, rvec;
    logic [3:0] req;
    logic [2:0] state;
    int num_errors = 0, num_checks = 0, n;
    logic seen_vec;
    row_s r;
    // Acknowledge table rows, halt then stop
    row_s rows [7] = '{'{0, 0, 0, 0, 7'h00, 0}, '{0, 0, 1, 0, 7'h00, 1}, '{0, 1, 0, 1, 7'h00, 0},
        '{0, 1, 1, 0, 7'h00, 0}, '{0, 1, 1, 1, 7'h00, 1}, '{1, 0, 1, 0, 7'h29, 1},
        '{1, 1, 0, 1, 7'h52, 0}};

    // Clock at 250 MHz
    always #2 clock_i = ~clock_i;

    standby_ctrl #(.OSC_BASE_CYCLES(16'h0004)) standby_ctrl_inst (.clock_i(clock_i),
        .resetn_i(resetn_i), .reset_pin_n_i(pin_n), .halt_instr_i(halt_i), .stop_instr_i(stop_i),
        .cpu_clk_src_i(src), .int_req_i(req), .interrupt_mask_flag_i(mask),
        .interrupt_priority_flag_i(pri), .global_interrupt_enable_flag_i(ie),
        .in_service_priority_flag_i(in_service_priority_flag), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .cpu_clk_en_o(clk_en), .hs_osc_en_o(osc_en), .port_hold_o(hold),
        .tmr8a_run_o(ra), .tmr8b_run_o(rb), .tmrh0_run_o(rh0), .watch_run_o(rw),
        .tmr16_run_o(r16), .vector_o(vec), .resume_o(res), .reset_vector_o(rvec), .state_o(state));

    cpu_seq_model cpu_seq_model_inst (.clock_i(clock_i), .resetn_i(resetn_i), .do_halt_i(do_halt),
        .do_stop_i(do_stop), .raise_i(raise), .drop_i(drop), .vector_i(vec), .cpu_clk_en_i(clk_en),
        .halt_instr_o(halt_i), .stop_instr_o(stop_i), .int_req_o(req));

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string name, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, g);
        end
    endtask : chk_rng

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clock_i);
        wr <= 0;
    endtask : wr_reg

    task automatic rd_reg(input string name, input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1;
        @(posedge clock_i);
        rd <= 0;
        @(negedge clock_i);
        chk(name, e, rdata);
    endtask : rd_reg

    // One-cycle pulses towards the model
    task automatic go(input logic stp);
        @(posedge clock_i);
        do_halt <= !stp;
        do_stop <= stp;
        @(posedge clock_i);
        do_halt <= 0;
        do_stop <= 0;
    endtask : go

    task automatic set_req(input logic [3:0] s, input logic d);
        @(posedge clock_i);
        raise <= s;
        drop <= d;
        @(posedge clock_i);
        raise <= 0;
        drop <= 0;
    endtask : set_req

    task automatic wait_state(input logic [2:0] s, input int lim);
        for (int k = 0; k <= lim; k++) begin
            @(negedge clock_i);
            if (state === s) return;
        end
        num_errors++;
        $display("mismatch state expected %h seen %h", s, state);
        end_sim();
    endtask : wait_state

    // Cycles from now until a vector or resume pulse
    task automatic count_wake;
        n = 0;
        seen_vec = 0;
        while (n < 300) begin
            @(negedge clock_i);
            n++;
            if (vec === 1'b1 || res === 1'b1) begin
                seen_vec = vec;
                return;
            end
        end
        num_errors++;
        $display("mismatch wake pulse expected 1 seen 0");
        end_sim();
    endtask : count_wake

    initial begin
        repeat (16) @(posedge clock_i);
        resetn_i <= 1;
        @(negedge clock_i);
        chk("reset outputs", 32'hdf, {clk_en, osc_en, hold, ra, rb, rh0, rw, r16});
        chk("reset state", 32'(standby_pkg::ST_RUN), state);
        rd_reg("ctrl reset", standby_pkg::CTRL_ADDR, 32'(standby_pkg::CTRL_RESET));
        $display("test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            pri <= {3'h0, r.pr};
            ie <= r.ie;
            in_service_priority_flag <= r.in_service_priority_flag;
            mask <= 4'he;
            wr_reg(standby_pkg::CTRL_ADDR, {25'h0, r.ctrl});
            go(r.stp);
            wait_state(r.stp ? standby_pkg::ST_STOP : standby_pkg::ST_HALT, 6);
            chk("standby outputs", r.stp ? {24'h0, 3'b001, r.ctrl[3], r.ctrl[4],
                r.ctrl[5] & r.ctrl[3], r.ctrl[6], 1'b0} : 32'h5f,
                {clk_en, osc_en, hold, ra, rb, rh0, rw, r16});
            set_req(4'h1, 0);
            wait_state(r.stp ? standby_pkg::ST_OSC : standby_pkg::ST_WAKE, 6);
            count_wake();
            if (r.stp) begin
                chk_rng("stop wait", 4 << r.ctrl[2:0], 4 << r.ctrl[2:0], n);
            end else begin
                chk_rng("halt wait", r.vec ? 8 : 2, r.vec ? 9 : 3, n);
            end
            chk("wake kind", r.vec, seen_vec);
            set_req(4'h0, 1);
            wait_state(standby_pkg::ST_RUN, 4);
            $display("test row %0d done", i);
        end
        // masked source holds halt, reset pin ends it
        mask <= 4'hf;
        ie <= 0;
        set_req(4'h1, 0);
        go(0);
        wait_state(standby_pkg::ST_HALT, 6);
        repeat (20) @(negedge clock_i);
        chk("masked halt", 32'(standby_pkg::ST_HALT), state);
        rd_reg("status", standby_pkg::STATUS_ADDR, 32'h1);
        pin_n <= 0;
        wait_state(standby_pkg::ST_RUN, 6);
        chk("reset vector", 1, rvec);
        pin_n <= 1;
        set_req(4'h0, 1);
        $display("test masked and reset pin done");
        mask <= 4'he;
        ie <= 1;
        pri <= 4'h0;
        set_req(4'h1, 0);
        go(0);
        wait_state(standby_pkg::ST_WAKE, 4);
        count_wake();
        chk_rng("pending halt wait", 8, 9, n);
        chk("pending halt kind", 1, seen_vec);
        $display("test pending halt done");
        // stop with request pending falls to the stabilization wait
        ie <= 0;
        wr_reg(standby_pkg::CTRL_ADDR, 32'h0);
        set_req(4'h1, 0);
        go(1);
        wait_state(standby_pkg::ST_OSC, 4);
        count_wake();
        chk_rng("pending stop wait", 4, 4, n);
        chk("pending stop kind", 0, seen_vec);
        set_req(4'h0, 1);
        $display("test pending stop done");
        // stop refused from the subsystem clock
        src <= standby_pkg::SRC_SUBSYSTEM;
        go(1);
        count_wake();
        chk("subsystem stop", 32'(standby_pkg::ST_RUN), state);
        chk("subsystem resume", 0, seen_vec);
        src <= standby_pkg::SRC_HIGH_SPEED;
        $display("test subsystem stop done");
        // Register saturation and unmapped reads
        wr_reg(standby_pkg::CTRL_ADDR, 32'h7f);
        rd_reg("ctrl sat", standby_pkg::CTRL_ADDR, {25'h0, 4'hf, standby_pkg::OSC_STABILIZATION_TIME_SELECT_MAX});
        rd_reg("unmapped", 8'h08, 32'h0);
        $display("test registers done");
        end_sim();
    end
endmodule : standby_halt_stop_control_tb
